/* File: design/fcps_host.sv */
// Host controller driving a parallel NOR flash by its strobes
`timescale 1ns/1ps
module fcps_host
   import fcps_pkg::*;
#(
   parameter int PWRUP_CYCLES = C_PWRUP,
   parameter int TOUT_CYCLES  = C_TOUT
)
(
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [19:0]      flash_addr,
   output logic [15:0]      flash_dq_out,
   output logic             flash_dq_oe,
   input  wire logic [15:0] flash_dq_in,
   output logic             flash_ce_n,
   output logic             flash_oe_n,
   output logic             flash_we_n,
   output logic             flash_reset_n,
   input  wire logic        flash_ready_in
);
   // ***************************************************
   // State
   // ***************************************************
   typedef enum logic [6:0] {
      ST_PWRUP = 7'b0000001,
      ST_IDLE  = 7'b0000010,
      ST_SETUP = 7'b0000100,
      ST_WLOW  = 7'b0001000,
      ST_WHIGH = 7'b0010000,
      ST_RLOW  = 7'b0100000,
      ST_POLL  = 7'b1000000
   } fcps_state_t;
   fcps_state_t state, next_state;
   logic [2:0]  op, next_op;
   logic [2:0]  step, next_step;
   logic [19:0] addr_reg, next_addr_reg;
   logic [15:0] data_reg, next_data_reg;
   logic [15:0] rdata, next_rdata;
   logic [15:0] prev_rd, next_prev_rd;
   logic        have_prev, next_have_prev;
   logic [31:0] cnt, next_cnt;
   logic [31:0] wait_cnt, next_wait_cnt;
   logic        busy, next_busy;
   logic        done, next_done;
   logic        err, next_err;
   logic        tout, next_tout;
   logic [19:0] next_flash_addr;
   logic [15:0] next_flash_dq_out;
   logic        next_flash_dq_oe;
   logic        next_ce_n, next_oe_n, next_we_n;
   logic [31:0] next_prdata;
   logic        next_pready, next_pslverr;
   logic        rdy_sync;
   logic [2:0]  seq_len;
   logic [19:0] seq_addr;
   logic [7:0]  seq_data;
   logic        apb_wr, apb_rd;

   fcps_sync u_rdy_sync
   (
      .clock (clock),
      .srst  (srst),
      .din   (flash_ready_in),
      .dout  (rdy_sync)
   );

   assign apb_wr = psel && penable && pwrite && !pready;
   assign apb_rd = psel && penable && !pwrite && !pready;

   // ***************************************************
   // Command sequence table
   // ***************************************************
   always_comb
   begin
      seq_addr = {4'h0, UNLOCK_A1};
      seq_data = D_AA;
      unique case (op)
         OP_PROG, OP_ID_IN, OP_ID_OUT: seq_len = 3'd3;
         OP_EXIT1, OP_READ:            seq_len = 3'd1;
         default:                      seq_len = 3'd6;
      endcase
      if (step == 3'd1 || step == 3'd4)
      begin
         seq_addr = {4'h0, UNLOCK_A2};
         seq_data = D_55;
      end
      else if (step == 3'd2)
      begin
         unique case (op)
            OP_PROG:   seq_data = D_PROG;
            OP_ID_IN:  seq_data = D_ID_IN;
            OP_ID_OUT: seq_data = D_ID_OUT;
            default:   seq_data = D_ERASE;
         endcase
      end
      else if (step == 3'd5)
      begin
         unique case (op)
            OP_CHIP:   seq_data = D_CHIP;
            OP_LOCK:   seq_data = D_LOCK;
            default:
            begin
               seq_addr = addr_reg;
               seq_data = D_SECTOR;
            end
         endcase
      end
      if (op == OP_EXIT1)
      begin
         seq_addr = addr_reg;
         seq_data = D_ID_OUT;
      end
   end

   // ***************************************************
   // Next-state logic
   // ***************************************************
   always_comb
   begin
      next_state = state;
      next_op = op;
      next_step = step;
      next_addr_reg = addr_reg;
      next_data_reg = data_reg;
      next_rdata = rdata;
      next_prev_rd = prev_rd;
      next_have_prev = have_prev;
      next_cnt = (cnt != 32'h0) ? cnt - 32'h1 : 32'h0;
      next_wait_cnt = wait_cnt;
      next_busy = busy;
      next_done = done;
      next_err = err;
      next_tout = tout;
      next_flash_addr = flash_addr;
      next_flash_dq_out = flash_dq_out;
      next_flash_dq_oe = flash_dq_oe;
      next_ce_n = flash_ce_n;
      next_oe_n = flash_oe_n;
      next_we_n = flash_we_n;
      next_prdata = prdata;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      if (apb_wr)
      begin
         next_pready = 1'b1;
         unique case (paddr)
            REG_ADDR: next_addr_reg = pwdata[19:0];
            REG_DATA: next_data_reg = pwdata[15:0];
            REG_CTRL:
            begin
               // Controller outside ST_IDLE (busy or in power-up) refuses a new command
               if (pwdata[CTRL_GO_BIT] && state == ST_IDLE)
               begin
                  next_op = pwdata[CTRL_CMD_LSB +: 3];
                  next_step = 3'd0;
                  next_busy = 1'b1;
                  next_done = 1'b0;
                  next_err = 1'b0;
                  next_tout = 1'b0;
                  next_have_prev = 1'b0;
                  next_state = ST_SETUP;
               end
               else if (pwdata[CTRL_GO_BIT])
                  next_pslverr = 1'b1;
            end
            default:  next_pslverr = 1'b1;
         endcase
      end
      else if (apb_rd)
      begin
         next_pready = 1'b1;
         unique case (paddr)
            REG_CTRL:   next_prdata = {29'h0, op};
            REG_ADDR:   next_prdata = {12'h0, addr_reg};
            REG_DATA:   next_prdata = {16'h0, data_reg};
            REG_STATUS: next_prdata = {27'h0, tout, err, done,
                                       rdy_sync, busy};
            REG_RDATA:  next_prdata = {16'h0, rdata};
            default:
            begin
               next_prdata = 32'h0;
               next_pslverr = 1'b1;
            end
         endcase
      end
      unique case (state)
         ST_PWRUP:
            if (cnt == 32'h0)
               next_state = ST_IDLE;
         ST_IDLE: ;
         ST_SETUP:
         begin
            next_ce_n = 1'b0;
            if (op == OP_READ)
            begin
               next_flash_addr = addr_reg;
               next_flash_dq_oe = 1'b0;
               next_oe_n = 1'b0;
               next_cnt = 32'(C_RD);
               next_state = ST_RLOW;
            end
            else
            begin
               next_oe_n = 1'b1;
               next_flash_addr = seq_addr;
               next_flash_dq_out = {8'h0, seq_data};
               if (op == OP_PROG && step == 3'd3)
               begin
                  next_flash_addr = addr_reg;
                  next_flash_dq_out = data_reg;
               end
               next_flash_dq_oe = 1'b1;
               next_cnt = 32'(C_WP);
               next_state = ST_WLOW;
            end
         end
         ST_WLOW:
            if (cnt == 32'h0)
            begin
               next_we_n = 1'b1;
               next_cnt = 32'(C_WPH);
               next_state = ST_WHIGH;
            end
            else
               next_we_n = 1'b0;
         ST_WHIGH:
            if (cnt == 32'h0)
            begin
               next_ce_n = 1'b1;
               next_flash_dq_oe = 1'b0;
               next_step = step + 3'd1;
               if (op == OP_PROG && step == 3'd2)
                  next_state = ST_SETUP;
               else if (step + 3'd1 < seq_len)
                  next_state = ST_SETUP;
               else if (op == OP_PROG || op == OP_CHIP
                        || op == OP_SECTOR)
               begin
                  next_wait_cnt = 32'h0;
                  next_state = ST_POLL;
                  next_cnt = 32'(C_WPH);
               end
               else
               begin
                  next_busy = 1'b0;
                  next_done = 1'b1;
                  next_state = ST_IDLE;
               end
            end
         ST_POLL:
         begin
            next_wait_cnt = wait_cnt + 32'h1;
            if (cnt == 32'h0)
            begin
               next_ce_n = 1'b0;
               next_oe_n = 1'b0;
               next_flash_addr = addr_reg;
               next_cnt = 32'(C_RD);
               next_state = ST_RLOW;
            end
            if (wait_cnt >= 32'(TOUT_CYCLES))
            begin
               next_tout = 1'b1;
               next_err = 1'b1;
               next_busy = 1'b0;
               next_state = ST_IDLE;
            end
         end
         ST_RLOW:
            if (cnt == 32'h0)
            begin
               next_rdata = flash_dq_in;
               next_prev_rd = flash_dq_in;
               next_have_prev = 1'b1;
               next_ce_n = 1'b1;
               next_oe_n = 1'b1;
               if (op == OP_READ)
               begin
                  next_busy = 1'b0;
                  next_done = 1'b1;
                  next_state = ST_IDLE;
               end
               else if (have_prev && prev_rd[ALT_BIT] == flash_dq_in[ALT_BIT]
                        && rdy_sync)
               begin
                  next_busy = 1'b0;
                  next_done = 1'b1;
                  if (op == OP_PROG && flash_dq_in[POLL_BIT]
                      != data_reg[POLL_BIT])
                     next_err = 1'b1;
                  next_state = ST_IDLE;
               end
               else
               begin
                  next_cnt = 32'(C_WPH);
                  next_state = ST_POLL;
               end
            end
         default: next_state = ST_IDLE;
      endcase
   end

   // ***************************************************
   // Registers
   // ***************************************************
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         state <= ST_PWRUP;
         op <= OP_READ;
         step <= 3'd0;
         addr_reg <= 20'h0;
         data_reg <= 16'h0;
         rdata <= 16'h0;
         prev_rd <= 16'h0;
         have_prev <= 1'b0;
         cnt <= 32'(PWRUP_CYCLES);
         wait_cnt <= 32'h0;
         busy <= 1'b0;
         done <= 1'b0;
         err <= 1'b0;
         tout <= 1'b0;
         flash_addr <= 20'h0;
         flash_dq_out <= 16'h0;
         flash_dq_oe <= 1'b0;
         flash_ce_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
         flash_reset_n <= 1'b0;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         state <= next_state;
         op <= next_op;
         step <= next_step;
         addr_reg <= next_addr_reg;
         data_reg <= next_data_reg;
         rdata <= next_rdata;
         prev_rd <= next_prev_rd;
         have_prev <= next_have_prev;
         cnt <= next_cnt;
         wait_cnt <= next_wait_cnt;
         busy <= next_busy;
         done <= next_done;
         err <= next_err;
         tout <= next_tout;
         flash_addr <= next_flash_addr;
         flash_dq_out <= next_flash_dq_out;
         flash_dq_oe <= next_flash_dq_oe;
         flash_ce_n <= next_ce_n;
         flash_oe_n <= next_oe_n;
         flash_we_n <= next_we_n;
         flash_reset_n <= 1'b1;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end
endmodule

/* File: common/fcps_pkg.sv */
// Constants and types for the flash command sequencer controller
// Function
// - Program is four writes: AA@5555, 55@2AAA, A0@5555, then address/data.
// - Lockout enable is six writes ending 40@5555; lock then persists.
// - Only low data byte and address bits 15 to 0 are decoded.
// - Sector erase ends with 30 written at a sector select address.
// - Address latched on later falling enable, data on first rising.
package fcps_pkg;
   // ***************************************************
   // Register map (APB byte addresses)
   // ***************************************************
   localparam logic [11:0] REG_CTRL   = 12'h000;
   localparam logic [11:0] REG_ADDR   = 12'h004;
   localparam logic [11:0] REG_DATA   = 12'h008;
   localparam logic [11:0] REG_STATUS = 12'h00c;
   localparam logic [11:0] REG_RDATA  = 12'h010;
   // Control fields
   localparam int CTRL_CMD_LSB = 0;
   localparam int CTRL_GO_BIT  = 31;
   localparam int STAT_BUSY    = 0;
   localparam int STAT_RDY     = 1;
   localparam int STAT_DONE    = 2;
   localparam int STAT_ERR     = 3;
   localparam int STAT_TOUT    = 4;
   // ***************************************************
   // Command codes and unlock addresses
   // ***************************************************
   localparam logic [15:0] UNLOCK_A1 = 16'h5555;
   localparam logic [15:0] UNLOCK_A2 = 16'h2aaa;
   localparam logic [7:0]  D_AA      = 8'haa;
   localparam logic [7:0]  D_55      = 8'h55;
   localparam logic [7:0]  D_PROG    = 8'ha0;
   localparam logic [7:0]  D_ERASE   = 8'h80;
   localparam logic [7:0]  D_CHIP    = 8'h10;
   localparam logic [7:0]  D_SECTOR  = 8'h30;
   localparam logic [7:0]  D_LOCK    = 8'h40;
   localparam logic [7:0]  D_ID_IN   = 8'h90;
   localparam logic [7:0]  D_ID_OUT  = 8'hf0;
   localparam logic [19:0] LOCK_OFS  = 20'h00002;
   localparam int POLL_BIT = 7;
   localparam int ALT_BIT  = 6;
   // ***************************************************
   // Operations requested by software
   // ***************************************************
   typedef enum logic [2:0] {
      OP_PROG   = 3'h0,
      OP_CHIP   = 3'h1,
      OP_SECTOR = 3'h2,
      OP_LOCK   = 3'h3,
      OP_ID_IN  = 3'h4,
      OP_ID_OUT = 3'h5,
      OP_EXIT1  = 3'h6,
      OP_READ   = 3'h7
   } fcps_op_t;
   // ***************************************************
   // Timing
   // ***************************************************
   localparam int CLK_MHZ        = 250;
   localparam int T_WP_NS        = 40;
   localparam int T_WPH_NS       = 40;
   localparam int T_RD_NS        = 100;
   localparam int T_PWRUP_MS     = 10;
   localparam int C_WP   = (T_WP_NS * CLK_MHZ + 999) / 1000;
   localparam int C_WPH  = (T_WPH_NS * CLK_MHZ + 999) / 1000;
   localparam int C_RD   = (T_RD_NS * CLK_MHZ + 999) / 1000;
   localparam int C_PWRUP = T_PWRUP_MS * 1000 * CLK_MHZ;
   localparam int C_TOUT  = 2_000_000_000;
endpackage

/* File: design/fcps_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module fcps_sync
   import fcps_pkg::*;
(
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic din,
   output logic      dout
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic       next_dout;
   always_comb
   begin
      next_stage = {stage[1:0], din};
      // Later stages must agree before the level moves
      next_dout  = (stage[2] == stage[1]) ? stage[2] : dout;
   end
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         stage <= 3'h7;
         dout  <= 1'b1;
      end
      else
      begin
         stage <= next_stage;
         dout  <= next_dout;
      end
   end
endmodule

/* File: dv/fcps_host_assertions.sv */
// Checks on the controller's bus answers and flash strobes
`timescale 1ns/1ps
module fcps_host_assertions
(
   input wire logic        clock,
   input wire logic        srst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [19:0] flash_addr,
   input wire logic [15:0] flash_dq_out,
   input wire logic        flash_dq_oe,
   input wire logic        flash_ce_n,
   input wire logic        flash_oe_n,
   input wire logic        flash_we_n,
   input wire logic        flash_reset_n
);
   // ***************************************
   // Sequences and properties
   // ***************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence

   a_apb_one_wait:
      assert property (s_setup ##1 s_access |-> !pready ##1 pready)
      else $error("pready not after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_write_strobe:
      assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
      else $error("write strobe without chip enable");
   a_drive_in_cycle:
      assert property (flash_dq_oe |-> !flash_ce_n && flash_oe_n)
      else $error("data driven outside write cycle");
   a_pulse_width:
      assert property ($fell(flash_we_n) |-> !flash_we_n [*8])
      else $error("write pulse too short");
   a_write_hold:
      assert property (!flash_we_n && $past(!flash_we_n) |->
                       $stable(flash_addr) && $stable(flash_dq_out))
      else $error("address or data moved in pulse");
   a_data_at_rise:
      assert property ($rose(flash_we_n) |-> flash_dq_oe && !flash_ce_n)
      else $error("data released before latch edge");
   a_reset_release:
      assert property ($fell(srst) |-> !flash_reset_n ##1 flash_reset_n)
      else $error("flash reset not released");
endmodule

/* File: dv/fcps_flash_model.sv */
// Behavioural parallel NOR flash facing the controller
`timescale 1ns/1ps
module fcps_flash_model
#(
   parameter int          PROG_NS  = 2000,
   parameter int          ERASE_NS = 6000,
   parameter logic        TOP_BOOT = 1'h0,
   parameter logic        HV_RESET = 1'h0,
   parameter realtime     PWRUP_NS = 50.0,
   // Arbitrary value
   parameter logic [15:0] MAKER_ID = 16'h0c3e
)
(
   input  wire logic [19:0] addr,
   input  wire logic [15:0] dq_in,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        reset_n,
   output logic [15:0]      dq_out,
   output logic             dq_en,
   output logic             busy_pull
);
   // ***************************************
   // Array and sequencer state
   // ***************************************
   logic [15:0] mem [logic [19:0]];
   logic [19:0] a_l, tgt;
   logic [15:0] pend;
   logic        lock = 1'h0, idm = 1'h0, tog = 1'h0, ers = 1'h0, sec;
   int          step = 0, ops = 0;
   realtime     t_fall = 0;

   localparam logic [7:0] BOOT_SA = TOP_BOOT ? 8'h7f : 8'h01;
   localparam logic [7:0] MAIN_SA = TOP_BOOT ? 8'h7b : 8'h7f;
   wire locked = lock && !HV_RESET;

   initial busy_pull = 1'h0;
   // Boot block at bottom or top
   function automatic logic boot(input logic [19:0] a);
      return TOP_BOOT ? a >= 20'hfc000 : a < 20'h04000;
   endfunction
   function automatic logic [15:0] arr(input logic [19:0] a);
      return mem.exists(a) ? mem[a] : 16'hffff;
   endfunction
   task automatic run(input logic e, s, input logic [19:0] a,
                      input logic [15:0] d);
      int n;
      n = ops;
      ers = e;
      sec = s;
      tgt = a;
      pend = d;
      busy_pull = 1'h1;
      fork
         begin
            #(e ? ERASE_NS : PROG_NS);
            if (n == ops)
               finish_op();
         end
      join_none
   endtask
   task automatic finish_op();
      if (!ers)
         mem[tgt] = arr(tgt) & pend;
      foreach (mem[k])
         if (ers && (boot(k) ? !locked && (!sec || tgt[19:12] == BOOT_SA)
                             : !sec || tgt[19:12] == MAIN_SA))
            mem[k] = 16'hffff;
      busy_pull = 1'h0;
   endtask
   task automatic decode();
      logic [15:0] w;
      logic [7:0]  d;
      w = a_l[15:0];
      d = dq_in[7:0];
      if (step == 0 && d == 8'hf0)
         idm = 1'h0;
      if (step == 2 && w == 16'h5555 && (d == 8'h90 || d == 8'hf0))
         idm = d == 8'h90;
      if (step == 3 && !(locked && boot(a_l)))
         run(1'h0, 1'h0, a_l, dq_in);
      if (step == 6 && w == 16'h5555 && d == 8'h40)
         lock = 1'h1;
      if (step == 6 && (w == 16'h5555 && d == 8'h10 || d == 8'h30))
         run(1'h1, d == 8'h30, a_l, 16'h0);
      case (step)
         0: step = (w == 16'h5555 && d == 8'haa) ? 1 : 0;
         1, 5: step = (w == 16'h2aaa && d == 8'h55) ? step + 1 : 0;
         2: step = w != 16'h5555 ? 0 : d == 8'ha0 ? 3 : d == 8'h80 ? 4 : 0;
         4: step = (w == 16'h5555 && d == 8'haa) ? 5 : 0;
         default: step = 0;
      endcase
   endtask
   always @(negedge we_n or negedge ce_n)
   begin
      a_l = addr;
      t_fall = $realtime;
   end
   always @(posedge we_n or posedge ce_n)
      if ((!ce_n || !we_n) && oe_n && reset_n && !busy_pull
          && $realtime - t_fall >= 15.0 && $realtime >= PWRUP_NS)
         decode();
   always @(negedge reset_n)
   begin
      if (busy_pull && !ers)
         mem[tgt] = ~pend;
      busy_pull = 1'h0;
      step = 0;
      ops++;
   end
   always @(negedge oe_n)
      tog = !tog;
   assign dq_en = !ce_n && !oe_n && reset_n;
   always @(addr or busy_pull or tog or idm or lock or ce_n or oe_n)
      if (busy_pull)
         dq_out = {8'h00, !ers && !pend[7], tog, 6'h00};
      else if (idm)
         dq_out = addr == (TOP_BOOT ? 20'hfc002 : 20'h00002)
                  ? {15'h0, lock} : MAKER_ID;
      else
         dq_out = arr(addr);
endmodule

/* File: dv/fcps_host_tb.sv */
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module fcps_host_tb
   import fcps_pkg::*;
   ;
   typedef struct {
      logic [31:0] e;
      logic [31:0] m;
      logic        er;
   } fcps_note_t;

   logic        clock = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        pready, pslverr, dq_oe, ce_n, oe_n, we_n, rst_n, m_en, busy;
   logic [19:0] f_addr, a;
   logic [15:0] dq_h, dq_m, dq, d, dq_last = 16'h0;
   fcps_note_t  notes [$];
   int          error_cnt = 0, n_tests = 0, seed = 54;

   always #2 clock = ~clock;
   // Floating bus shows a moving pattern, never a stale value
   always @(posedge clock) dq_last <= dq;
   assign dq = dq_oe ? dq_h : m_en ? dq_m : ~dq_last;

   fcps_host #(.PWRUP_CYCLES(20), .TOUT_CYCLES(5000)) fcps_host_i (
      .clock(clock), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .flash_addr(f_addr),
      .flash_dq_out(dq_h), .flash_dq_oe(dq_oe), .flash_dq_in(dq),
      .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
      .flash_reset_n(rst_n), .flash_ready_in(!busy));
   fcps_flash_model fcps_flash_model_i (
      .addr(f_addr), .dq_in(dq), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .reset_n(rst_n), .dq_out(dq_m), .dq_en(m_en), .busy_pull(busy));

   // ***************************************
   // Bus tasks and checking
   // ***************************************
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] ad,
                       input logic [31:0] wd, m, e, input logic er);
      int n;
      n = 0;
      @(posedge clock);
      notes.push_back('{e, m, er});
      psel <= 1'h1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'h1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'h1 && n < 40);
      if (n >= 40)
         error_cnt++;
      q = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // Results are judged where they appear, against the oldest note
   always @(posedge clock)
      if (psel && penable && pready === 1'h1)
      begin
         fcps_note_t nt;
         nt = notes.pop_front();
         chk("prdata", nt.e, prdata & nt.m);
         chk("pslverr", {31'h0, nt.er}, {31'h0, pslverr});
      end
   task automatic wr(input logic [11:0] ad, input logic [31:0] wd,
                     input logic er);
      xfer(1'h1, ad, wd, 32'h0, 32'h0, er);
   endtask
   task automatic op(input fcps_op_t c, input logic [19:0] ad,
                     input logic [15:0] wd, input logic er);
      int n;
      n = 0;
      wr(REG_ADDR, {12'h0, ad}, 1'h0);
      wr(REG_DATA, {16'h0, wd}, 1'h0);
      wr(REG_CTRL, 32'h8000_0000 | 32'(c), 1'h0);
      q = 32'h1;
      while (q[STAT_BUSY] !== 1'h0 && n < 4000)
      begin
         xfer(1'h0, REG_STATUS, 32'h0, 32'h0, 32'h0, 1'h0);
         n++;
      end
      if (n >= 4000)
         error_cnt++;
      // Finished: no timeout, done and ready set, busy clear
      xfer(1'h0, REG_STATUS, 32'h0, 32'h1f, {27'h0, 1'h0, er, 3'h6}, 1'h0);
   endtask
   task automatic peek(input logic [19:0] ad, input logic [15:0] e);
      op(OP_READ, ad, 16'h0, 1'h0);
      xfer(1'h0, REG_RDATA, 32'h0, 32'hffff, {16'h0, e}, 1'h0);
   endtask
   task automatic close_out();
      if (error_cnt == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ***************************************
   // Scenarios
   // ***************************************
   initial
   begin
      repeat (3) @(posedge clock);
      srst <= 1'h0;
      wr(REG_CTRL, 32'h8000_0000, 1'h1);
      wr(REG_ADDR, 32'h000f_5a5a, 1'h0);
      xfer(1'h0, REG_ADDR, 32'h0, 32'hfffff, 32'hf5a5a, 1'h0);
      xfer(1'h0, 12'h020, 32'h0, 32'hffff_ffff, 32'h0, 1'h1);
      repeat (20) @(posedge clock);
      op(OP_PROG, 20'h00200, 16'h5a5a, 1'h0);
      op(OP_ID_IN, 20'h0, 16'h0, 1'h0);
      peek(20'h00002, 16'h0000);
      op(OP_ID_OUT, 20'h0, 16'h0, 1'h0);
      op(OP_LOCK, 20'h0, 16'h0, 1'h0);
      op(OP_ID_IN, 20'h0, 16'h0, 1'h0);
      peek(20'h00002, 16'h0001);
      op(OP_EXIT1, 20'h12345, 16'h0, 1'h0);
      peek(20'h00200, 16'h5a5a);
      op(OP_PROG, 20'h00100, 16'h0000, 1'h1);
      peek(20'h00100, 16'hffff);
      op(OP_PROG, 20'h10000, 16'h12a5, 1'h0);
      op(OP_PROG, 20'h10000, 16'hff0f, 1'h0);
      peek(20'h10000, 16'h1205);
      op(OP_PROG, 20'h10000, 16'h0080, 1'h1);
      for (int i = 0; i < 3; i++)
      begin
         a = {4'(2 + i), 16'($random(seed))};
         d = 16'($random(seed));
         op(OP_PROG, a, d, 1'h0);
         peek(a, d);
      end
      op(OP_SECTOR, 20'h7f000, 16'h0, 1'h0);
      peek(20'h10000, 16'hffff);
      op(OP_PROG, 20'h10000, 16'h0f0f, 1'h0);
      op(OP_CHIP, 20'h0, 16'h0, 1'h0);
      peek(20'h10000, 16'hffff);
      peek(20'h00200, 16'h5a5a);
      wr(REG_ADDR, 32'h0003_0000, 1'h0);
      wr(REG_DATA, 32'h0, 1'h0);
      wr(REG_CTRL, 32'h8000_0000, 1'h0);
      repeat (40) @(posedge clock);
      wr(REG_CTRL, 32'h8000_0000, 1'h1);
      repeat (150) @(posedge clock);
      srst <= 1'h1;
      repeat (3) @(posedge clock);
      srst <= 1'h0;
      xfer(1'h0, REG_STATUS, 32'h0, 32'h1, 32'h0, 1'h0);
      chk("ready_line", 32'h1, {31'h0, !busy});
      close_out();
   end
   initial
   begin
      #300us;
      error_cnt++;
      close_out();
   end
endmodule

bind fcps_host fcps_host_assertions fcps_host_assertions_i (
   .clock(clock), .srst(srst), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr),
   .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
   .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
   .flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n));
